// ==== inc/hpbs_map.svh ====
`ifndef HPBS_MAP_SVH
`define HPBS_MAP_SVH

// Target I/O register byte addresses
`define HPBS_PORT_CONFIG_ADDR   16'h3802
`define HPBS_SEMAPHORE_A_ADDR   16'h39F8
`define HPBS_DMA_CONFIG_ADDR    16'h3A02
`define HPBS_DMA_PAGE_ADDR      16'h3A04
`define HPBS_DMA_ADDRESS_ADDR   16'h3A06
`define HPBS_DMA_COUNT_ADDR     16'h3A08

// Values written by the sequencer
`define HPBS_PORT_CONFIG_RESET  16'h0F00
`define HPBS_PORT_CONFIG_WIDE   16'h0F01
`define HPBS_WIDE_BIT           0
`define HPBS_DMA_CFG_AUTOBUF    16'h0010
`define HPBS_DMA_CFG_START      16'h0017
`define HPBS_SEMAPHORE_RELEASE  16'h0001

// Block flag fields
`define HPBS_FLAG_MEM16_BIT     0
`define HPBS_FLAG_FINAL_BIT     1
`define HPBS_FLAG_ZERO_BIT      2

// Loader header walk: two file control words, then flag, address MSW, LSW, count
`define HPBS_HDR_FLAG_IDX       3'h2
`define HPBS_HDR_AMSW_IDX       3'h3
`define HPBS_HDR_ALSW_IDX       3'h4
`define HPBS_HDR_CNT_IDX        3'h5
`define HPBS_DMA_LAST_IDX       3'h4

`endif

// ==== inc/hpbs_pkg.sv ====
package hpbs_pkg;

	typedef enum logic [3:0] {
		HPBS_IDLE    = 4'b0000,
		HPBS_WID_ADR = 4'b0001,
		HPBS_WID_LO  = 4'b0010,
		HPBS_WID_HI  = 4'b0011,
		HPBS_GET_HDR = 4'b0100,
		HPBS_DMA_ADR = 4'b0101,
		HPBS_DMA_DAT = 4'b0110,
		HPBS_PAY_GET = 4'b0111,
		HPBS_PAY_PUT = 4'b1000,
		HPBS_SEM_ADR = 4'b1001,
		HPBS_SEM_DAT = 4'b1010,
		HPBS_DM_ADR  = 4'b1011,
		HPBS_DM_RD   = 4'b1100,
		HPBS_PM_ADR  = 4'b1101,
		HPBS_PM_RD   = 4'b1110,
		HPBS_FIN     = 4'b1111
	} hpbs_state_t;

	typedef enum logic [1:0] {
		HPBS_C_IDLE = 2'b00,
		HPBS_C_WAIT = 2'b01,
		HPBS_C_GAP  = 2'b10
	} hpbs_cyc_state_t;

endpackage

// ==== core/hpbs_cycle.sv ====
`timescale 1ns/100ps
// One port cycle: address phase or data phase, held until the target acknowledges
module hpbs_cycle import hpbs_pkg::*; (
	input  wire logic        clk_sys,
	input  wire logic        nrst,
	input  wire logic        req,
	input  wire logic        is_addr,
	input  wire logic        is_write,
	input  wire logic        is_io,
	input  wire logic        high_address_line,
	input  wire logic [15:0] wdata,
	output logic             idle,
	output logic             done,
	output logic [15:0]      rdata,
	input  wire logic        ack,
	input  wire logic [15:0] bus_in,
	output logic [15:0]      bus_out,
	output logic             bus_oe_n,
	output logic             ale,
	output logic             high_address_line_out,
	output logic             io_sel_n,
	output logic             mem_sel_n,
	output logic             wr_n,
	output logic             rd_n
);
	hpbs_cyc_state_t state_r;
	wire logic       start = req && (state_r == HPBS_C_IDLE);
	wire logic       ackd  = ack && (state_r == HPBS_C_WAIT);

	assign idle = (state_r == HPBS_C_IDLE);

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			state_r   <= HPBS_C_IDLE;
			done      <= 1'b0;
			rdata     <= 16'h0000;
			bus_out   <= 16'h0000;
			bus_oe_n  <= 1'b1;
			ale       <= 1'b0;
			high_address_line_out  <= 1'b0;
			io_sel_n  <= 1'b1;
			mem_sel_n <= 1'b1;
			wr_n      <= 1'b1;
			rd_n      <= 1'b1;
		end else begin
			done <= ackd;
			unique case (state_r)
				HPBS_C_IDLE: begin
					if (start) begin
						state_r   <= HPBS_C_WAIT;
						bus_out   <= wdata;
						bus_oe_n  <= !(is_addr || is_write);
						ale       <= is_addr;
						high_address_line_out  <= high_address_line;
						io_sel_n  <= !is_io;
						mem_sel_n <= is_io;
						wr_n      <= !(is_write && !is_addr);
						rd_n      <= !(!is_write && !is_addr);
					end
				end
				HPBS_C_WAIT: begin
					// Strobes stay until the target answers, however long it takes
					if (ackd) begin
						state_r   <= HPBS_C_GAP;
						rdata     <= bus_in;
						ale       <= 1'b0;
						io_sel_n  <= 1'b1;
						mem_sel_n <= 1'b1;
						wr_n      <= 1'b1;
						rd_n      <= 1'b1;
					end
				end
				HPBS_C_GAP: begin
					// One idle cycle lets the target drop its acknowledge
					state_r  <= HPBS_C_IDLE;
					bus_oe_n <= 1'b1;
				end
				default: state_r <= HPBS_C_IDLE;
			endcase
		end
	end
endmodule

// ==== core/hpbs_boot.sv ====
// Contract
// - Widen target port to 16 bits first
// - Widen with bytes 0x01 then 0x0F
// - Write autobuffer mode to DMA config
// - Write start page, then start address
// - Write word count, then start DMA
// - Payload as data cycles, no address
// - Each block header programs target DMA
// - Semaphore release only after last block
// - Release writes 0x0001 to 0x39F8
// - Data memory: address shifted one, high line
// - Program memory: address shifted two, high line
// - Check handshake locations after release
// - Final-block flag bit ends the boot
// - Zero-init block: send zeros, no payload
// - Flag bit 0 picks words per target word
// - Target address from LSW and MSW low byte
`timescale 1ns/100ps
`include "hpbs_map.svh"
module hpbs_boot import hpbs_pkg::*; (
	input  wire logic        CLK_SYS,
	input  wire logic        NRST,
	input  wire logic        START,
	output logic             BUSY,
	output logic             DONE,
	output logic             BOOT_OK,
	input  wire logic        LDR_VALID,
	input  wire logic [15:0] LDR_DATA,
	output logic             LDR_READY,
	input  wire logic [15:0] DM_CHECK_ADDR,
	input  wire logic [15:0] DM_CHECK_VALUE,
	input  wire logic [15:0] PM_CHECK_ADDR,
	input  wire logic [23:0] PM_CHECK_VALUE,
	input  wire logic [15:0] MUXED_ADDR_DATA_BUS_IN,
	output logic [15:0]      MUXED_ADDR_DATA_BUS_OUT,
	output logic             MUXED_ADDR_DATA_BUS_OE_N,
	output logic             HIGH_ADDRESS_LINE,
	output logic             ADDRESS_LATCH_STROBE,
	input  wire logic        TARGET_ACKNOWLEDGE,
	output logic             IO_SPACE_SELECT_N,
	output logic             MEMORY_SPACE_SELECT_N,
	output logic             WRITE_STROBE_N,
	output logic             READ_STROBE_N
);
	hpbs_state_t state_r;
	hpbs_state_t state_nxt;
	logic        issued_r;
	logic [2:0]  hdr_idx_r;
	logic [2:0]  dma_idx_r;
	logic [15:0] flag_r;
	logic [15:0] amsw_r;
	logic [15:0] alsw_r;
	logic [15:0] cnt_r;
	logic [16:0] words_r;
	logic [15:0] pay_r;
	logic        pm_word_r;
	logic [7:0]  pm_lo_r;
	logic        dm_ok_r;
	logic        cyc_idle;
	logic        cyc_done;
	logic [15:0] cyc_rdata;

	function automatic logic [15:0] dma_reg(input logic [2:0] idx);
		unique case (idx)
			3'h0:    dma_reg = `HPBS_DMA_CONFIG_ADDR;
			3'h1:    dma_reg = `HPBS_DMA_PAGE_ADDR;
			3'h2:    dma_reg = `HPBS_DMA_ADDRESS_ADDR;
			3'h3:    dma_reg = `HPBS_DMA_COUNT_ADDR;
			default: dma_reg = `HPBS_DMA_CONFIG_ADDR;
		endcase
	endfunction

	function automatic logic [15:0] dma_val(input logic [2:0] idx, input logic [15:0] amsw,
		input logic [15:0] alsw, input logic [15:0] cnt);
		unique case (idx)
			3'h0:    dma_val = `HPBS_DMA_CFG_AUTOBUF;
			3'h1:    dma_val = {8'h00, amsw[7:0]};
			3'h2:    dma_val = alsw;
			3'h3:    dma_val = cnt;
			default: dma_val = `HPBS_DMA_CFG_START;
		endcase
	endfunction

	wire logic        take      = LDR_READY && LDR_VALID;
	wire logic        zero_blk  = flag_r[`HPBS_FLAG_ZERO_BIT];
	wire logic        final_blk = flag_r[`HPBS_FLAG_FINAL_BIT];
	// Narrow memory takes one loader word per target word, wide memory two
	wire logic [16:0] blk_words = flag_r[`HPBS_FLAG_MEM16_BIT] ? {1'b0, cnt_r} : {cnt_r, 1'b0};
	wire hpbs_state_t after_blk = final_blk ? HPBS_SEM_ADR : HPBS_GET_HDR;
	wire hpbs_state_t pay_state = zero_blk ? HPBS_PAY_PUT : HPBS_PAY_GET;
	wire logic [16:0] dm_byte   = {DM_CHECK_ADDR, 1'b0};
	wire logic [17:0] pm_byte   = {PM_CHECK_ADDR, 2'b00};

	wire logic bus_st = (state_r != HPBS_IDLE) && (state_r != HPBS_GET_HDR)
		&& (state_r != HPBS_PAY_GET) && (state_r != HPBS_FIN);
	wire logic cyc_req = bus_st && !issued_r && cyc_idle;
	wire logic is_addr = (state_r == HPBS_WID_ADR) || (state_r == HPBS_DMA_ADR) || (state_r == HPBS_SEM_ADR)
		|| (state_r == HPBS_DM_ADR) || (state_r == HPBS_PM_ADR);
	wire logic is_read = (state_r == HPBS_DM_RD) || (state_r == HPBS_PM_RD);
	wire logic is_mem  = (state_r == HPBS_DM_ADR) || (state_r == HPBS_PM_ADR) || is_read;
	// DMA payload goes out in memory space with no address phase
	wire logic is_io   = !is_mem && (state_r != HPBS_PAY_PUT);

	wire logic [15:0] wide_val = `HPBS_PORT_CONFIG_WIDE;
	logic [15:0] cyc_wdata;
	always_comb begin
		unique case (state_r)
			HPBS_WID_ADR: cyc_wdata = `HPBS_PORT_CONFIG_ADDR;
			// Narrow port: low byte travels first, both on the low lane
			HPBS_WID_LO:  cyc_wdata = {8'h00, wide_val[7:0]};
			HPBS_WID_HI:  cyc_wdata = {8'h00, wide_val[15:8]};
			HPBS_DMA_ADR: cyc_wdata = dma_reg(dma_idx_r);
			HPBS_DMA_DAT: cyc_wdata = dma_val(dma_idx_r, amsw_r, alsw_r, cnt_r);
			HPBS_PAY_PUT: cyc_wdata = zero_blk ? 16'h0000 : pay_r;
			HPBS_SEM_ADR: cyc_wdata = `HPBS_SEMAPHORE_A_ADDR;
			HPBS_SEM_DAT: cyc_wdata = `HPBS_SEMAPHORE_RELEASE;
			HPBS_DM_ADR:  cyc_wdata = dm_byte[15:0];
			HPBS_PM_ADR:  cyc_wdata = pm_byte[15:0];
			default:      cyc_wdata = 16'h0000;
		endcase
	end

	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			HPBS_IDLE:    if (START) state_nxt = HPBS_WID_ADR;
			HPBS_WID_ADR: if (cyc_done) state_nxt = HPBS_WID_LO;
			HPBS_WID_LO:  if (cyc_done) state_nxt = HPBS_WID_HI;
			HPBS_WID_HI:  if (cyc_done) state_nxt = HPBS_GET_HDR;
			HPBS_GET_HDR: if (take && hdr_idx_r == `HPBS_HDR_CNT_IDX) state_nxt = HPBS_DMA_ADR;
			HPBS_DMA_ADR: if (cyc_done) state_nxt = HPBS_DMA_DAT;
			HPBS_DMA_DAT: begin
				if (cyc_done) begin
					if (dma_idx_r != `HPBS_DMA_LAST_IDX)
						state_nxt = HPBS_DMA_ADR;
					else if (blk_words == 17'h00000)
						state_nxt = after_blk;
					else
						state_nxt = pay_state;
				end
			end
			HPBS_PAY_GET: if (take) state_nxt = HPBS_PAY_PUT;
			HPBS_PAY_PUT: begin
				if (cyc_done)
					state_nxt = (words_r == 17'h00001) ? after_blk : pay_state;
			end
			HPBS_SEM_ADR: if (cyc_done) state_nxt = HPBS_SEM_DAT;
			HPBS_SEM_DAT: if (cyc_done) state_nxt = HPBS_DM_ADR;
			HPBS_DM_ADR:  if (cyc_done) state_nxt = HPBS_DM_RD;
			HPBS_DM_RD:   if (cyc_done) state_nxt = HPBS_PM_ADR;
			HPBS_PM_ADR:  if (cyc_done) state_nxt = HPBS_PM_RD;
			HPBS_PM_RD:   if (cyc_done && pm_word_r) state_nxt = HPBS_FIN;
			HPBS_FIN:     state_nxt = HPBS_IDLE;
		endcase
	end

	always_ff @(posedge CLK_SYS or negedge NRST) begin
		if (!NRST) begin
			state_r   <= HPBS_IDLE;
			issued_r  <= 1'b0;
			LDR_READY <= 1'b0;
			BUSY      <= 1'b0;
			DONE      <= 1'b0;
		end else begin
			state_r   <= state_nxt;
			issued_r  <= cyc_done ? 1'b0 : (issued_r || cyc_req);
			LDR_READY <= (state_nxt == HPBS_GET_HDR) || (state_nxt == HPBS_PAY_GET);
			BUSY      <= (state_nxt != HPBS_IDLE);
			DONE      <= (state_r == HPBS_FIN);
		end
	end

	// Header capture; file control words are read and dropped
	always_ff @(posedge CLK_SYS or negedge NRST) begin
		if (!NRST) begin
			hdr_idx_r <= 3'h0;
			flag_r    <= 16'h0000;
			amsw_r    <= 16'h0000;
			alsw_r    <= 16'h0000;
			cnt_r     <= 16'h0000;
			pay_r     <= 16'h0000;
		end else if (state_r == HPBS_IDLE) begin
			hdr_idx_r <= 3'h0;
		end else if (take) begin
			if (state_r == HPBS_PAY_GET)
				pay_r <= LDR_DATA;
			else begin
				unique case (hdr_idx_r)
					`HPBS_HDR_FLAG_IDX: flag_r <= LDR_DATA;
					`HPBS_HDR_AMSW_IDX: amsw_r <= LDR_DATA;
					`HPBS_HDR_ALSW_IDX: alsw_r <= LDR_DATA;
					`HPBS_HDR_CNT_IDX:  cnt_r  <= LDR_DATA;
					default:            ;
				endcase
				hdr_idx_r <= (hdr_idx_r == `HPBS_HDR_CNT_IDX) ? `HPBS_HDR_FLAG_IDX : hdr_idx_r + 3'h1;
			end
		end
	end

	always_ff @(posedge CLK_SYS or negedge NRST) begin
		if (!NRST) begin
			dma_idx_r <= 3'h0;
			words_r   <= 17'h00000;
		end else if (state_r == HPBS_GET_HDR) begin
			dma_idx_r <= 3'h0;
		end else if (cyc_done && state_r == HPBS_DMA_DAT) begin
			dma_idx_r <= dma_idx_r + 3'h1;
			words_r   <= blk_words;
		end else if (cyc_done && state_r == HPBS_PAY_PUT) begin
			words_r   <= words_r - 17'h00001;
		end
	end

	// Handshake check after release
	always_ff @(posedge CLK_SYS or negedge NRST) begin
		if (!NRST) begin
			pm_word_r <= 1'b0;
			pm_lo_r   <= 8'h00;
			dm_ok_r   <= 1'b0;
			BOOT_OK   <= 1'b0;
		end else if (START && state_r == HPBS_IDLE) begin
			BOOT_OK   <= 1'b0;
			pm_word_r <= 1'b0;
		end else if (cyc_done && state_r == HPBS_DM_RD) begin
			dm_ok_r <= (cyc_rdata == DM_CHECK_VALUE);
		end else if (cyc_done && state_r == HPBS_PM_RD) begin
			pm_word_r <= !pm_word_r;
			if (!pm_word_r)
				pm_lo_r <= cyc_rdata[15:8];
			else
				BOOT_OK <= dm_ok_r && ({cyc_rdata, pm_lo_r} == PM_CHECK_VALUE);
		end
	end

	hpbs_cycle u_cycle (
		.clk_sys   (CLK_SYS),
		.nrst      (NRST),
		.req       (cyc_req),
		.is_addr   (is_addr),
		.is_write  (!is_read),
		.is_io     (is_io),
		.high_address_line      (is_mem && is_addr),
		.wdata     (cyc_wdata),
		.idle      (cyc_idle),
		.done      (cyc_done),
		.rdata     (cyc_rdata),
		.ack       (TARGET_ACKNOWLEDGE),
		.bus_in    (MUXED_ADDR_DATA_BUS_IN),
		.bus_out   (MUXED_ADDR_DATA_BUS_OUT),
		.bus_oe_n  (MUXED_ADDR_DATA_BUS_OE_N),
		.ale       (ADDRESS_LATCH_STROBE),
		.high_address_line_out  (HIGH_ADDRESS_LINE),
		.io_sel_n  (IO_SPACE_SELECT_N),
		.mem_sel_n (MEMORY_SPACE_SELECT_N),
		.wr_n      (WRITE_STROBE_N),
		.rd_n      (READ_STROBE_N)
	);
endmodule

// ==== bench/hpbs_boot_monitor.sv ====
`timescale 1ns/100ps
module hpbs_boot_monitor (
	input wire logic        CLK_SYS,
	input wire logic        NRST,
	input wire logic        DONE,
	input wire logic        BOOT_OK,
	input wire logic [15:0] MUXED_ADDR_DATA_BUS_OUT,
	input wire logic        MUXED_ADDR_DATA_BUS_OE_N,
	input wire logic        HIGH_ADDRESS_LINE,
	input wire logic        ADDRESS_LATCH_STROBE,
	input wire logic        TARGET_ACKNOWLEDGE,
	input wire logic        IO_SPACE_SELECT_N,
	input wire logic        MEMORY_SPACE_SELECT_N,
	input wire logic        WRITE_STROBE_N,
	input wire logic        READ_STROBE_N
);
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (!NRST);
	wire         ph = ADDRESS_LATCH_STROBE || !WRITE_STROBE_N || !READ_STROBE_N;
	wire         ack = TARGET_ACKNOWLEDGE;
	chk_hold_write: assert property (!WRITE_STROBE_N && !ack |=> !WRITE_STROBE_N && $stable(MUXED_ADDR_DATA_BUS_OUT))
		else $error("write phase left before acknowledge");
	chk_hold_addr: assert property (ADDRESS_LATCH_STROBE && !ack |=> ADDRESS_LATCH_STROBE[*1] ##0 $stable(MUXED_ADDR_DATA_BUS_OUT))
		else $error("address phase left before acknowledge");
	chk_hold_read: assert property (!READ_STROBE_N && !ack |=> !READ_STROBE_N)
		else $error("read phase left before acknowledge");
	chk_release_ack: assert property (ph && ack |=> !ph && IO_SPACE_SELECT_N && MEMORY_SPACE_SELECT_N)
		else $error("phase not released after acknowledge");
	chk_addr_drive: assert property (ADDRESS_LATCH_STROBE |-> WRITE_STROBE_N && READ_STROBE_N && !MUXED_ADDR_DATA_BUS_OE_N)
		else $error("address phase without driven bus");
	chk_high_line: assert property (ADDRESS_LATCH_STROBE |-> HIGH_ADDRESS_LINE == !MEMORY_SPACE_SELECT_N)
		else $error("high address line wrong in address phase");
	chk_read_float: assert property (!READ_STROBE_N |-> MUXED_ADDR_DATA_BUS_OE_N && WRITE_STROBE_N)
		else $error("bus driven during read");
	chk_one_space: assert property (IO_SPACE_SELECT_N || MEMORY_SPACE_SELECT_N)
		else $error("both spaces selected");
	chk_done_pulse: assert property (DONE |=> !DONE)
		else $error("done longer than one cycle");
	cov_boot_ok: cover property (DONE && BOOT_OK);
	cov_boot_bad: cover property (DONE && !BOOT_OK);
	cov_read_ack: cover property (!READ_STROBE_N && ack);
endmodule

// ==== bench/hpbs_target_model.sv ====
`timescale 1ns/100ps
module hpbs_target_model (
	input  wire logic        clk,
	input  wire logic        nrst,
	input  wire logic [15:0] bus_o,
	input  wire logic        oe_n,
	input  wire logic        ale,
	input  wire logic        io_n,
	input  wire logic        mem_n,
	input  wire logic        wr_n,
	input  wire logic        rd_n,
	input  wire logic [1:0]  dly,
	input  wire logic [15:0] hs_dm,
	input  wire logic [23:0] hs_pm,
	output logic             ack,
	output logic [15:0]      bus
);
	logic [15:0] cfg_r, adr_r, da_r, cn_r, last_r, rv;
	logic [1:0]  cnt_r, rn_r;
	logic        run_r, dma_r, hi_r;
	logic [15:0] mem [0:65535];
	wire         act = (!io_n || !mem_n) && (ale || !wr_n || !rd_n);
	wire         narrow = !cfg_r[0] || hi_r;
	// Handshake words exist only once the loaded program runs
	assign rv = !run_r ? ~last_r : rn_r == 0 ? hs_dm : rn_r == 1 ? {hs_pm[7:0], 8'h00} : hs_pm[23:8];
	// Released bus toggles so a stale value is never read
	assign bus = !oe_n ? bus_o : !rd_n ? rv : ~last_r;
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ack <= 1'b0;
			cnt_r <= 2'h0;
			cfg_r <= 16'h0F00;
			hi_r <= 1'b0;
			run_r <= 1'b0;
			dma_r <= 1'b0;
			rn_r <= 2'h0;
			last_r <= 16'h5A5A;
		end else begin
			last_r <= bus;
			cnt_r <= ack || !act ? 2'h0 : cnt_r + 2'h1;
			ack <= !ack && act && cnt_r == dly;
			if (ack && act) begin
				if (ale) begin
					adr_r <= bus_o;
				end else if (!rd_n) begin
					rn_r <= rn_r + 2'h1;
				end else if (!mem_n && dma_r) begin
					mem[da_r] <= bus_o;
					da_r <= da_r + 16'h1;
					cn_r <= cn_r - 16'h1;
					dma_r <= cn_r != 16'h1;
				end else if (adr_r == 16'h3802 && narrow) begin
					if (hi_r) cfg_r[15:8] <= bus_o[7:0];
					else cfg_r[7:0] <= bus_o[7:0];
					hi_r <= !hi_r;
				end else case (adr_r)
					16'h3802: cfg_r <= bus_o;
					16'h39F8: run_r <= bus_o[0];
					16'h3A02: dma_r <= bus_o == 16'h0017;
					16'h3A06: da_r <= bus_o;
					16'h3A08: cn_r <= bus_o;
					default: ;
				endcase
			end
		end
	end
endmodule

// ==== bench/test_hpbs_boot.sv ====
`timescale 1ns/100ps
module test_hpbs_boot;
	logic        clk = 0, nrst = 0, start = 0, lv = 0, tk, rs;
	logic        ack, busy, done, ok, lr, oe_n, high_address_line, ale, io_n, mem_n, wr_n, rd_n;
	logic [15:0] ld = 0, dm_a = 0, dm_v = 0, pm_a = 0, hs_dm = 0, bus, bo;
	logic [23:0] pm_v = 0, hs_pm = 0;
	logic [1:0]  dly = 0;
	logic [23:0] exq[$];
	logic [15:0] ldq[$];
	int          failures = 0, n_checks = 0, cyc = 0;
	hpbs_boot dut (.CLK_SYS(clk), .NRST(nrst), .START(start), .BUSY(busy), .DONE(done), .BOOT_OK(ok),
		.LDR_VALID(lv), .LDR_DATA(ld), .LDR_READY(lr), .DM_CHECK_ADDR(dm_a), .DM_CHECK_VALUE(dm_v),
		.PM_CHECK_ADDR(pm_a), .PM_CHECK_VALUE(pm_v), .MUXED_ADDR_DATA_BUS_IN(bus),
		.MUXED_ADDR_DATA_BUS_OUT(bo), .MUXED_ADDR_DATA_BUS_OE_N(oe_n), .HIGH_ADDRESS_LINE(high_address_line),
		.ADDRESS_LATCH_STROBE(ale), .TARGET_ACKNOWLEDGE(ack), .IO_SPACE_SELECT_N(io_n),
		.MEMORY_SPACE_SELECT_N(mem_n), .WRITE_STROBE_N(wr_n), .READ_STROBE_N(rd_n));
	hpbs_target_model tgt (.clk(clk), .nrst(nrst), .bus_o(bo), .oe_n(oe_n), .ale(ale), .io_n(io_n),
		.mem_n(mem_n), .wr_n(wr_n), .rd_n(rd_n), .dly(dly), .hs_dm(hs_dm), .hs_pm(hs_pm), .ack(ack), .bus(bus));
	initial forever #2.5 clk = ~clk;
	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic tally_and_finish;
		$display("checks=%0d failures=%0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic ev(input logic a, input logic io, input logic w, input logic r, input logic h,
		input logic [15:0] d);
		exq.push_back({1'b0, r, a, !io, io, !w, !r, h, d});
	endtask
	task automatic io(input logic [15:0] a, input logic [15:0] d);
		ev(1, 1, 0, 0, 0, a);
		ev(0, 1, 1, 0, 0, d);
	endtask
	task automatic blk(input logic [15:0] f, input logic [23:0] a, input int c);
		logic [15:0] w;
		ldq.push_back(f);
		ldq.push_back({8'h00, a[23:16]});
		ldq.push_back(a[15:0]);
		ldq.push_back(c[15:0]);
		io(16'h3A02, 16'h0010);
		io(16'h3A04, {8'h00, a[23:16]});
		io(16'h3A06, a[15:0]);
		io(16'h3A08, c[15:0]);
		io(16'h3A02, 16'h0017);
		for (int i = 0; i < (f[0] ? c : 2 * c); i++) begin
			w = f[2] ? 16'h0000 : 16'($urandom);
			if (!f[2]) ldq.push_back(w);
			ev(0, 0, 1, 0, 0, w);
		end
	endtask
	task automatic rst;
		@(posedge clk);
		#1 nrst = 0;
		repeat (8) @(posedge clk);
		chk({busy, done, ok, lr, oe_n, wr_n, rd_n, io_n, mem_n, ale, high_address_line}, 24'h00007C);
		ldq.delete();
		exq.delete();
		#1 nrst = 1;
		chk(tgt.cfg_r, 16'h0F00);
	endtask
	// Bad bit 0 spoils the program word, bit 1 the data word
	task automatic boot(input logic [1:0] bad, input logic cut);
		ldq.push_back(16'h00AB);
		ldq.push_back(16'h0001);
		ev(1, 1, 0, 0, 0, 16'h3802);
		ev(0, 1, 1, 0, 0, 16'h0001);
		ev(0, 1, 1, 0, 0, 16'h000F);
		blk(16'h0001, 24'h008000, 5);
		blk(16'h0000, 24'h012340, 3);
		blk(16'h0001, 24'h00A000, 0);
		blk(16'h0007, 24'h009000, 4);
		io(16'h39F8, 16'h0001);
		{dm_a, pm_a, hs_dm} = 48'({$urandom, $urandom});
		hs_pm = 24'($urandom);
		dm_v = hs_dm ^ {15'h0000, bad[1]};
		pm_v = hs_pm ^ {23'h000000, bad[0]};
		ev(1, 0, 0, 0, 1, {dm_a[14:0], 1'b0});
		ev(0, 0, 0, 1, 0, 16'h0000);
		ev(1, 0, 0, 0, 1, {pm_a[13:0], 2'b00});
		ev(0, 0, 0, 1, 0, 16'h0000);
		ev(0, 0, 0, 1, 0, 16'h0000);
		start = 1;
		@(posedge clk);
		#1 start = 0;
		chk(busy, 1'b1);
		if (cut) begin
			repeat (60) @(posedge clk);
			$display("abort test done");
			return;
		end
		for (int n = 0; n < 5000 && done !== 1'b1; n++) begin
			@(posedge clk);
			#1;
		end
		chk({busy, ok}, {1'b0, bad == 2'b00});
		chk(24'(exq.size()), 24'h0);
		$display("boot test done");
	endtask
	always @(posedge clk) begin
		tk = lv && lr;
		rs = nrst;
		cyc++;
		if (cyc > 20000) begin
			failures++;
			tally_and_finish();
		end
		if (nrst && ack && !(io_n && mem_n))
			chk({1'b0, oe_n, ale, io_n, mem_n, wr_n, rd_n, high_address_line, rd_n ? bo : 16'h0000},
				exq.size() ? exq.pop_front() : 24'hFFFFFF);
		#1;
		if (tk) void'(ldq.pop_front());
		if (!rs) lv = 0;
		else if (tk || !lv) begin
			lv = ldq.size() != 0 && $urandom_range(3) != 0;
			ld = ldq.size() ? ldq[0] : 16'h0000;
		end
		dly = 2'($urandom_range(3));
	end
	initial begin
		void'($urandom(32'h60bb));
		rst();
		boot(2'b00, 1'b0);
		chk(tgt.cfg_r, 16'h0F01);
		chk(tgt.mem[16'h9003], 16'h0000);
		rst();
		boot(2'b01, 1'b0);
		rst();
		boot(2'b00, 1'b1);
		rst();
		boot(2'b10, 1'b0);
		tally_and_finish();
	end
endmodule
bind hpbs_boot hpbs_boot_monitor u_mon (.CLK_SYS, .NRST, .DONE, .BOOT_OK, .MUXED_ADDR_DATA_BUS_OUT,
	.MUXED_ADDR_DATA_BUS_OE_N, .HIGH_ADDRESS_LINE, .ADDRESS_LATCH_STROBE, .TARGET_ACKNOWLEDGE,
	.IO_SPACE_SELECT_N, .MEMORY_SPACE_SELECT_N, .WRITE_STROBE_N, .READ_STROBE_N);
